// file: logic/can_mode_ctrl.v
// CAN operating-mode controller with APB register access
`timescale 1ns/100ps
`include "can_mode_defs.vh"

module can_mode_ctrl (
  // Clock and reset
  input wire clock,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Bus pins
  input wire bus_receive_pin,
  output reg bus_transmit_pin,
  output reg tx_pin_owned,
  output reg rx_pin_owned,
  // Protocol engine side
  input wire engine_tx,
  input wire engine_busy,
  input wire engine_error,
  input wire engine_tx_done,
  input wire sleeping,
  output reg engine_rx,
  output reg rx_enable,
  output reg tx_enable,
  output reg ack_enable,
  output reg ignore_errors,
  output reg copy_assembly,
  output reg tx_start,
  output reg wake_interrupt_flag
);

  // Register state
  reg [2:0] mode_request_field;
  reg [2:0] mode_status_field;
  reg wake_filter_enable;
  reg [15:0] config_word;
  reg [15:0] bit_divider;
  reg transmit_request_bit;
  reg transmit_aborted_flag;
  reg [7:0] tx_err_count;
  reg [7:0] rx_err_count;
  reg rx_sync1, rx_sync2;
  reg [15:0] bit_timer;
  reg [3:0] recessive_count;
  reg tx_waiting;
  reg [3:0] filter_count;
  reg filtered_rx;
  reg rx_prev;
  wire bus_idle;
  wire access;
  wire config_locked;
  wire bit_tick;
  wire in_init;

  // Modes that may start a frame: normal, listen-all and loopback
  function tx_allowed;
    input [2:0] m;
    begin
      tx_allowed = (m == `MODE_NORMAL) || (m == `MODE_LISTEN_ALL) ||
        (m == `MODE_LOOPBACK);
    end
  endfunction

  assign access = psel & penable;
  assign in_init = (mode_status_field == `MODE_INIT);
  assign config_locked = !in_init;
  assign bit_tick = (bit_timer == 16'h0000);
  assign bus_idle = (recessive_count == `IDLE_BITS);

  // Receive pin passes two flops before any logic sees it
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
    end else begin
      rx_sync1 <= bus_receive_pin;
      rx_sync2 <= rx_sync1;
    end
  end

  // Bit timer and recessive run counter; saturates at the idle count
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_timer <= 16'h0000;
      recessive_count <= 4'h0;
    end else begin
      bit_timer <= bit_tick ? bit_divider : bit_timer - 16'h0001;
      if (!rx_sync2) begin
        recessive_count <= 4'h0;
      end else if (bit_tick && !bus_idle) begin
        recessive_count <= recessive_count + 4'h1;
      end
    end
  end

  // Mode transition; status follows the request on an idle bus, or at once out of disable; init always waits for an idle bus and an idle engine
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_status_field <= `CTRL1_RESET_MODE;
    end else if (mode_request_field != mode_status_field) begin
      if (mode_request_field == `MODE_INIT) begin
        if (!engine_busy && bus_idle) begin
          mode_status_field <= mode_request_field;
        end
      end else if (bus_idle || mode_status_field == `MODE_DISABLE) begin
        mode_status_field <= mode_request_field;
      end
    end
  end

  // APB slave: one wait state, error on unmapped accesses or locked writes
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_request_field <= `CTRL1_RESET_MODE;
      wake_filter_enable <= 1'b0;
      config_word <= 16'h0000;
      bit_divider <= `BITDIV_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Ready follows the first access edge, where writes take effect
      pready <= access & !pready;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `ADDR_CTRL1: prdata <= {21'h000000, mode_request_field,
            mode_status_field, 5'h00};
          `ADDR_CFG2: prdata <= {17'h00000, wake_filter_enable, 14'h0000};
          `ADDR_CONFIG: prdata <= {16'h0000, config_word};
          `ADDR_TXCTL: prdata <= {30'h00000000, transmit_aborted_flag,
            transmit_request_bit};
          `ADDR_ERRCNT: prdata <= {16'h0000, tx_err_count, rx_err_count};
          `ADDR_STAT: prdata <= {29'h00000000, wake_interrupt_flag,
            tx_waiting, bus_idle};
          `ADDR_BITDIV: prdata <= {16'h0000, bit_divider};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (access && !pready) begin
        case (paddr)
          `ADDR_CTRL1: if (pwrite) begin
            mode_request_field <= pwdata[`REQ_HI:`REQ_LO];
          end
          `ADDR_CFG2: if (pwrite) begin
            if (config_locked) pslverr <= 1'b1;
            else wake_filter_enable <= pwdata[`WAKFILT_BIT];
          end
          `ADDR_CONFIG: if (pwrite) begin
            if (config_locked) pslverr <= 1'b1;
            else config_word <= pwdata[15:0];
          end
          `ADDR_BITDIV: if (pwrite) begin
            if (config_locked) pslverr <= 1'b1;
            else bit_divider <= pwdata[15:0];
          end
          `ADDR_TXCTL, `ADDR_ERRCNT, `ADDR_STAT: begin
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Transmit request, idle wait and abort; set by hardware wins over clear
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      transmit_request_bit <= 1'b0;
      transmit_aborted_flag <= 1'b0;
      tx_waiting <= 1'b0;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      if (access && !pready && pwrite && paddr == `ADDR_TXCTL) begin
        if (pwdata[0]) transmit_request_bit <= 1'b1;
        if (pwdata[1]) transmit_aborted_flag <= 1'b0;
        if (pwdata[0] && !transmit_request_bit) tx_waiting <= 1'b1;
      end
      if (tx_waiting && mode_request_field == `MODE_DISABLE) begin
        tx_waiting <= 1'b0;
        transmit_request_bit <= 1'b0;
        transmit_aborted_flag <= 1'b1;
      end else if (tx_waiting && bus_idle &&
          tx_allowed(mode_status_field)) begin
        tx_waiting <= 1'b0;
        tx_start <= 1'b1;
      end else if (engine_tx_done) begin
        transmit_request_bit <= 1'b0;
      end
    end
  end

  // Error counters; engine error bumps both when counting is active
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_err_count <= 8'h00;
      rx_err_count <= 8'h00;
    end else if (in_init) begin
      tx_err_count <= 8'h00;
      rx_err_count <= 8'h00;
    end else if (engine_error && (mode_status_field == `MODE_NORMAL ||
        mode_status_field == `MODE_LOOPBACK)) begin
      if (tx_err_count != 8'hFF) tx_err_count <= tx_err_count + 8'h01;
      if (rx_err_count != 8'hFF) rx_err_count <= rx_err_count + 8'h01;
    end
  end

  // Wake filter: receive must stay dominant for several cycles
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      filter_count <= 4'h0;
      filtered_rx <= 1'b1;
      rx_prev <= 1'b1;
      wake_interrupt_flag <= 1'b0;
    end else begin
      rx_prev <= filtered_rx;
      if (!(wake_filter_enable && sleeping)) begin
        filtered_rx <= rx_sync2;
        filter_count <= 4'h0;
      end else if (rx_sync2 == filtered_rx) begin
        filter_count <= 4'h0;
      end else if (filter_count == `WAKE_FILTER_CYCLES - 4'h1) begin
        filtered_rx <= rx_sync2;
        filter_count <= 4'h0;
      end else begin
        filter_count <= filter_count + 4'h1;
      end
      // Wake on bus activity in disable; set beats clear
      if (mode_status_field == `MODE_DISABLE && rx_prev && !filtered_rx) begin
        wake_interrupt_flag <= 1'b1;
      end else if (access && !pready && pwrite && paddr == `ADDR_STAT &&
          pwdata[2]) begin
        wake_interrupt_flag <= 1'b0;
      end
    end
  end

  // Pin ownership and engine controls per mode, registered
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_transmit_pin <= 1'b1;
      tx_pin_owned <= 1'b0;
      rx_pin_owned <= 1'b0;
      engine_rx <= 1'b1;
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      ack_enable <= 1'b0;
      ignore_errors <= 1'b0;
      copy_assembly <= 1'b0;
    end else begin
      bus_transmit_pin <= 1'b1;
      tx_pin_owned <= 1'b0;
      rx_pin_owned <= 1'b0;
      engine_rx <= 1'b1;
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      ack_enable <= 1'b0;
      ignore_errors <= 1'b0;
      copy_assembly <= 1'b0;
      case (mode_status_field)
        `MODE_NORMAL: begin
          bus_transmit_pin <= engine_tx;
          tx_pin_owned <= 1'b1;
          rx_pin_owned <= 1'b1;
          engine_rx <= rx_sync2;
          rx_enable <= 1'b1;
          tx_enable <= 1'b1;
          ack_enable <= 1'b1;
        end
        `MODE_LISTEN_ONLY: begin
          rx_pin_owned <= 1'b1;
          engine_rx <= rx_sync2;
          rx_enable <= 1'b1;
        end
        `MODE_LISTEN_ALL: begin
          bus_transmit_pin <= engine_tx;
          tx_pin_owned <= 1'b1;
          rx_pin_owned <= 1'b1;
          engine_rx <= rx_sync2;
          rx_enable <= 1'b1;
          tx_enable <= 1'b1;
          ignore_errors <= 1'b1;
          copy_assembly <= engine_error;
        end
        `MODE_LOOPBACK: begin
          engine_rx <= engine_tx;
          rx_enable <= 1'b1;
          tx_enable <= 1'b1;
          ack_enable <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// file: logic/can_mode_defs.vh
// Register offsets, field positions, mode codes and timing counts
`ifndef CAN_MODE_DEFS_VH
`define CAN_MODE_DEFS_VH
// Byte addresses of the registers on APB
`define ADDR_CTRL1 12'h000
`define ADDR_CFG2 12'h004
`define ADDR_CONFIG 12'h008
`define ADDR_TXCTL 12'h00C
`define ADDR_ERRCNT 12'h010
`define ADDR_STAT 12'h014
`define ADDR_BITDIV 12'h018
// Field positions
`define REQ_HI 10
`define REQ_LO 8
`define STS_HI 7
`define STS_LO 5
`define WAKFILT_BIT 14
// Mode codes, shared by request and status fields
// Own codes for init, listen, loopback
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LOOPBACK 3'h2
`define MODE_LISTEN_ONLY 3'h3
`define MODE_INIT 3'h4
`define MODE_LISTEN_ALL 3'h7
// Reset values
`define CTRL1_RESET_MODE 3'h4
`define BITDIV_RESET 16'h0018
// Recessive bits that mark an idle bus
`define IDLE_BITS 4'hB
// Wake filter length in clock cycles
`define WAKE_FILTER_CYCLES 4'h8
`endif

// file: sim/can_bus_node.sv
// Behavioural model of the other nodes sharing the CAN bus
`timescale 1ns/100ps
module can_bus_node (
  // Clock
  input wire logic clock,
  // Bench control and device transmit side
  input wire logic talk,
  input wire logic dut_tx,
  input wire logic dut_tx_on,
  // Wired-AND bus level
  output logic rx_level
);
  logic [2:0] phase = 3'h0;
  // Dominant for four cycles of every eight breaks any idle run while talking
  always @(posedge clock) begin
    phase <= phase + 3'h1;
  end
  // Dominant wins; a released device pin leaves the bus recessive
  assign rx_level = (talk ? phase[2] : 1'b1) & (dut_tx_on ? dut_tx : 1'b1);
endmodule

// file: sim/can_mode_checker.sv
// Port-level assertions for the CAN operating-mode controller
`timescale 1ns/100ps
module can_mode_checker (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  // Bus pins and engine side
  input wire bus_receive_pin,
  input wire bus_transmit_pin,
  input wire tx_pin_owned,
  input wire ack_enable,
  input wire tx_enable,
  input wire engine_error,
  input wire copy_assembly,
  input wire tx_start,
  input wire wake_interrupt_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Bus answers last exactly one cycle
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("error response without ready");
  a_tx_released: assert property (
    !tx_pin_owned && !$past(tx_pin_owned) |-> bus_transmit_pin)
    else $error("released transmit pin not recessive");
  a_start_idle: assert property (
    tx_start |-> $past(bus_receive_pin, 3))
    else $error("transmission started on a busy bus");
  a_start_pulse: assert property (tx_start |=> !tx_start)
    else $error("start pulse longer than one cycle");
  a_copy_cause: assert property (
    $rose(copy_assembly) |-> $past(engine_error))
    else $error("assembly copy without an error");
  a_ack_owned: assert property (ack_enable |-> tx_enable)
    else $error("acknowledge enabled while transmit is off");
  // Only a register write may clear the wake flag
  a_wake_sticky: assert property (
    wake_interrupt_flag && !(psel && penable && pwrite)
    |=> wake_interrupt_flag)
    else $error("wake flag dropped without a write");
  c_refused: cover property (pslverr);
  c_started: cover property (tx_start);
  c_copied: cover property (copy_assembly);
endmodule

bind can_mode_ctrl can_mode_checker i_can_mode_checker (.clock, .rst,
  .psel, .penable, .pwrite, .pready, .pslverr, .bus_receive_pin,
  .bus_transmit_pin, .tx_pin_owned, .ack_enable, .tx_enable,
  .engine_error, .copy_assembly, .tx_start, .wake_interrupt_flag);

// file: sim/can_mode_ctrl_tb_top.sv
// Self-checking bench for the CAN operating-mode controller
`timescale 1ns/100ps
`include "can_mode_defs.vh"
module can_mode_ctrl_tb_top;
  logic clock, rst, psel, penable, pwrite, talk, sleeping, er;
  logic engine_tx, engine_busy, engine_error, engine_tx_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, bus_receive_pin, bus_transmit_pin, tx_pin_owned;
  wire rx_pin_owned, engine_rx, rx_enable, tx_enable, ack_enable;
  wire ignore_errors, copy_assembly, tx_start, wake_interrupt_flag;
  int fails = 0;
  int compares = 0;
  int n;
  can_mode_ctrl i_can_mode_ctrl (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_receive_pin,
    .bus_transmit_pin, .tx_pin_owned, .rx_pin_owned, .engine_tx,
    .engine_busy, .engine_error, .engine_tx_done, .sleeping, .engine_rx,
    .rx_enable, .tx_enable, .ack_enable, .ignore_errors, .copy_assembly,
    .tx_start, .wake_interrupt_flag);
  can_bus_node i_can_bus_node (.clock, .talk, .dut_tx(bus_transmit_pin),
    .dut_tx_on(tx_pin_owned), .rx_level(bus_receive_pin));
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; the request stands until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      fails++;
      test_done;
    end
  endtask
  task req(input logic [2:0] m);
    apb(1'b1, `ADDR_CTRL1, {21'h0, m, 8'h00});
  endtask
  // Poll the status field, bounded, then compare it
  task wait_mode(input logic [2:0] m);
    apb(1'b0, `ADDR_CTRL1, 32'h0);
    for (int i = 0; i < 60 && rd[7:5] !== m; i++)
      apb(1'b0, `ADDR_CTRL1, 32'h0);
    chk(rd[7:5], m);
    if (rd[7:5] !== m) test_done;
  endtask
  task rest(input int c);
    repeat (c) @(posedge clock);
  endtask
  initial begin
    {psel, penable, pwrite, engine_busy, engine_error} = 5'h00;
    {engine_tx_done, sleeping, paddr, pwdata} = 46'h0;
    engine_tx = 1'b1;
    talk = 1'b1;
    rst = 1'b1;
    rest(2);
    rst <= 1'b0;
    apb(1'b0, `ADDR_CTRL1, 32'h0);
    chk(rd[10:5], {`MODE_INIT, `MODE_INIT});
    apb(1'b0, `ADDR_BITDIV, 32'h0);
    chk(rd, {16'h0, `BITDIV_RESET});
    // Short bit time keeps the idle waits brief
    apb(1'b1, `ADDR_BITDIV, 32'h3);
    chk(er, 1'b0);
    apb(1'b1, `ADDR_CFG2, 32'h4000);
    chk(er, 1'b0);
    req(`MODE_NORMAL);
    rest(200);
    apb(1'b0, `ADDR_CTRL1, 32'h0);
    chk(rd[7:5], `MODE_INIT);
    talk <= 1'b0;
    wait_mode(`MODE_NORMAL);
    chk(tx_pin_owned, 1'b1);
    apb(1'b1, `ADDR_CONFIG, 32'h5);
    chk(er, 1'b1);
    apb(1'b0, `ADDR_CONFIG, 32'h0);
    chk(rd, 32'h0);
    // Request while busy, then count the idle run before the start
    talk <= 1'b1;
    rest(8);
    apb(1'b1, `ADDR_TXCTL, 32'h1);
    talk <= 1'b0;
    for (n = 0; n < 200 && tx_start !== 1'b1; n++) @(posedge clock);
    if (n >= 200) begin
      fails++;
      test_done;
    end
    chk(n > 30, 1'b1);
    engine_tx_done <= 1'b1;
    rest(1);
    engine_tx_done <= 1'b0;
    talk <= 1'b1;
    rest(8);
    apb(1'b1, `ADDR_TXCTL, 32'h1);
    req(`MODE_DISABLE);
    apb(1'b0, `ADDR_TXCTL, 32'h0);
    chk(rd[1:0], 2'b10);
    talk <= 1'b0;
    wait_mode(`MODE_DISABLE);
    chk({tx_pin_owned, rx_pin_owned}, 2'b00);
    chk({rx_enable, tx_enable}, 2'b00);
    // Filtered sleep: short dominant pulses must not wake the block
    sleeping <= 1'b1;
    talk <= 1'b1;
    rest(16);
    apb(1'b0, `ADDR_STAT, 32'h0);
    chk(rd[2], 1'b0);
    sleeping <= 1'b0;
    rest(16);
    talk <= 1'b0;
    apb(1'b0, `ADDR_STAT, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, `ADDR_STAT, 32'h4);
    apb(1'b0, `ADDR_STAT, 32'h0);
    chk(rd[2], 1'b0);
    req(`MODE_LOOPBACK);
    wait_mode(`MODE_LOOPBACK);
    engine_tx <= 1'b0;
    rest(3);
    chk({engine_rx, tx_pin_owned, rx_pin_owned}, 3'b000);
    chk(bus_transmit_pin, 1'b1);
    engine_tx <= 1'b1;
    // Counters run in loopback, so the later clear in init is visible
    engine_error <= 1'b1;
    rest(1);
    engine_error <= 1'b0;
    apb(1'b0, `ADDR_ERRCNT, 32'h0);
    chk(rd[15:0], 16'h0101);
    req(`MODE_LISTEN_ALL);
    wait_mode(`MODE_LISTEN_ALL);
    chk(ignore_errors, 1'b1);
    engine_error <= 1'b1;
    rest(1);
    engine_error <= 1'b0;
    rest(1);
    chk(copy_assembly, 1'b1);
    req(`MODE_LISTEN_ONLY);
    wait_mode(`MODE_LISTEN_ONLY);
    chk({tx_pin_owned, rx_pin_owned, ack_enable}, 3'b010);
    chk({rx_enable, tx_enable}, 2'b10);
    engine_error <= 1'b1;
    rest(1);
    engine_error <= 1'b0;
    apb(1'b0, `ADDR_ERRCNT, 32'h0);
    chk(rd[15:0], 16'h0101);
    engine_busy <= 1'b1;
    req(`MODE_INIT);
    rest(200);
    apb(1'b0, `ADDR_CTRL1, 32'h0);
    chk(rd[7:5], `MODE_LISTEN_ONLY);
    engine_busy <= 1'b0;
    wait_mode(`MODE_INIT);
    apb(1'b0, `ADDR_ERRCNT, 32'h0);
    chk(rd[15:0], 16'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({er, rd}, 33'h100000000);
    test_done;
  end
endmodule
